//--- design/nontemporal_store_prefetch_fence.sv
// non-temporal store, prefetch hint and store fence unit of the core
`default_nettype none
`include "nt_params.svh"

module nontemporal_store_prefetch_fence
(
   input  wire logic                         clk,
   input  wire logic                         resetn,
   input  wire logic                         req_valid,
   output var  logic                         req_ready,
   input  wire nt_pkg::op_t                  req_op,
   input  wire logic [`NT_ADDR_W-1:0]        req_addr,
   input  wire logic [`NT_REQ_BITS-1:0]      req_data,
   input  wire logic [`NT_MASK_W-1:0]        req_mask,
   input  wire nt_pkg::mem_type_t            req_mtype,
   input  wire logic                         cache_l1_hit,
   input  wire logic                         cache_l2_hit,
   output var  logic                         evict_valid,
   output var  logic [`NT_ADDR_W-1:0]        evict_addr,
   input  wire logic                         evict_ready,
   output var  logic                         fill_valid,
   output var  logic [`NT_ADDR_W-1:0]        fill_addr,
   output var  logic                         fill_l1,
   output var  logic                         fill_l2,
   output var  logic                         fill_nt,
   input  wire logic                         fill_ready,
   output var  logic                         bus_valid,
   output var  logic [`NT_ADDR_W-1:0]        bus_addr,
   output var  logic [`NT_LINE_BITS-1:0]     bus_data,
   output var  logic [`NT_LINE_BYTES-1:0]    bus_be,
   output var  logic                         bus_wc,
   input  wire logic                         bus_ready,
   output var  logic                         fence_done
);
   import nt_pkg::*;

   typedef struct packed
   {
      state_t                              st;
      logic                                req_ready;
      op_t                                 p_op;
      logic [`NT_ADDR_W-1:0]               p_addr;
      logic [`NT_REQ_BITS-1:0]             p_data;
      logic [`NT_MASK_W-1:0]               p_mask;
      mem_type_t                           p_mtype;
      logic                                p_l1;
      logic                                p_l2;
      logic                                p_live;
      logic                                wc_valid;
      logic [`NT_ADDR_W-`NT_OFS_W-1:0]     wc_line;
      logic [`NT_LINE_BITS-1:0]            wc_data;
      logic [`NT_LINE_BYTES-1:0]           wc_be;
      logic                                bus_valid;
      logic [`NT_ADDR_W-1:0]               bus_addr;
      logic [`NT_LINE_BITS-1:0]            bus_data;
      logic [`NT_LINE_BYTES-1:0]           bus_be;
      logic                                bus_wc;
      logic                                evict_valid;
      logic [`NT_ADDR_W-1:0]               evict_addr;
      logic                                fill_valid;
      logic [`NT_ADDR_W-1:0]               fill_addr;
      logic                                fill_l1;
      logic                                fill_l2;
      logic                                fill_nt;
      logic                                fence_done;
   } unit_state_t;

   unit_state_t                        q;
   unit_state_t                        next_q;
   logic [`NT_LINE_BITS-1:0]           lane_data;
   logic [`NT_LINE_BYTES-1:0]          lane_be;
   logic [`NT_LINE_BITS-1:0]           merged_data;
   logic [`NT_LINE_BYTES-1:0]          merged_be;
   logic [`NT_ADDR_W-`NT_OFS_W-1:0]    p_line;
   logic                               cacheable;
   logic                               is_prefetch;
   logic                               no_move;

   assign p_line = q.p_addr[`NT_ADDR_W-1:`NT_OFS_W];

   // byte lanes of the pending store placed into its 32-byte line
   // masked store reuses quadword lanes; unmasked bytes keep old data
   genvar i;
   generate
      for (i = 0; i < `NT_LINE_BYTES; i++)
      begin : g_lane
         localparam int QB = i % `NT_QW_BYTES;
         localparam int PB = i % `NT_PS_BYTES;
         logic qw_sel;
         logic ps_sel;
         assign qw_sel = (int'(q.p_addr[`NT_QW_LANE_HI:`NT_QW_LANE_LO])
                          == i / `NT_QW_BYTES);
         assign ps_sel = (int'(q.p_addr[`NT_PS_LANE]) == i / `NT_PS_BYTES);
         assign lane_be[i] =
            (q.p_op == NT_STORE_QUADWORD)      ? qw_sel :
            (q.p_op == NT_STORE_PACKED_SINGLE) ? ps_sel :
            (q.p_op == MASKED_BYTE_STORE)      ? qw_sel & q.p_mask[QB] :
            1'b0;
         assign lane_data[i*8 +: 8] =
            (q.p_op == NT_STORE_PACKED_SINGLE) ? q.p_data[PB*8 +: 8]
                                               : q.p_data[QB*8 +: 8];
         assign merged_be[i] = q.wc_be[i] | lane_be[i];
         assign merged_data[i*8 +: 8] = lane_be[i] ? lane_data[i*8 +: 8]
                                                   : q.wc_data[i*8 +: 8];
      end
   endgenerate

   always_comb
   begin
      // write-protected counts as uncacheable, so its stores go straight to the bus uncombined
      cacheable = (q.p_mtype == WRITE_BACK_TYPE)
               || (q.p_mtype == WRITE_THROUGH_TYPE)
               || (q.p_mtype == WRITE_COMBINING_TYPE);
      is_prefetch = (q.p_op == PREFETCH_ALL_LEVELS)
                 || (q.p_op == PREFETCH_LEVEL_TWO_A)
                 || (q.p_op == PREFETCH_LEVEL_TWO_B)
                 || (q.p_op == PREFETCH_NONTEMPORAL);
      unique case (q.p_op)
         PREFETCH_LEVEL_TWO_A,
         PREFETCH_LEVEL_TWO_B: no_move = q.p_l1 | q.p_l2;
         default:              no_move = q.p_l1;
      endcase
   end

   always_comb
   begin
      next_q = q;
      next_q.fence_done = 1'b0;
      unique case (q.st)
         ST_IDLE:
         begin
            next_q.req_ready = 1'b1;
            // hit flags are sampled once, together with the request
            if (req_valid && q.req_ready)
            begin
               next_q.p_op      = req_op;
               next_q.p_addr    = req_addr;
               next_q.p_data    = req_data;
               next_q.p_mask    = req_mask;
               next_q.p_mtype   = req_mtype;
               next_q.p_l1      = cache_l1_hit;
               next_q.p_l2      = cache_l2_hit;
               next_q.p_live    = 1'b1;
               next_q.req_ready = 1'b0;
               next_q.st        = ST_EXEC;
            end
         end
         ST_EXEC:
         begin
            if (q.p_op == STORE_FENCE)
            begin
               if (q.wc_valid)
               begin
                  next_q.bus_valid = 1'b1;
                  next_q.bus_addr  = {q.wc_line, `NT_OFS_ZERO};
                  next_q.bus_data  = q.wc_data;
                  next_q.bus_be    = q.wc_be;
                  next_q.bus_wc    = 1'b1;
                  next_q.wc_valid  = 1'b0;
                  next_q.wc_be     = '0;
                  next_q.st        = ST_DRAIN;
               end
               else
               begin
                  // nothing older is pending, so the fence completes now
                  next_q.fence_done = 1'b1;
                  next_q.p_live     = 1'b0;
                  next_q.req_ready  = 1'b1;
                  next_q.st         = ST_IDLE;
               end
            end
            else if (is_prefetch)
            begin
               if (no_move)
               begin
                  next_q.p_live    = 1'b0;
                  next_q.req_ready = 1'b1;
                  next_q.st        = ST_IDLE;
               end
               else
               begin
                  next_q.fill_valid = 1'b1;
                  next_q.fill_addr  = {p_line, `NT_OFS_ZERO};
                  next_q.fill_l1 = (q.p_op == PREFETCH_ALL_LEVELS)
                                || (q.p_op == PREFETCH_NONTEMPORAL);
                  next_q.fill_l2 = (q.p_op != PREFETCH_NONTEMPORAL);
                  next_q.fill_nt = (q.p_op == PREFETCH_NONTEMPORAL);
                  next_q.st      = ST_FILL;
               end
            end
            else if (q.wc_valid && (!cacheable || q.wc_line != p_line))
            begin
               // one line is buffered: another line or an uncached store
               // pushes it out first, so uncached writes stay behind it
               next_q.bus_valid = 1'b1;
               next_q.bus_addr  = {q.wc_line, `NT_OFS_ZERO};
               next_q.bus_data  = q.wc_data;
               next_q.bus_be    = q.wc_be;
               next_q.bus_wc    = 1'b1;
               next_q.wc_valid  = 1'b0;
               next_q.wc_be     = '0;
               next_q.st        = ST_DRAIN;
            end
            else if (!cacheable)
            begin
               next_q.bus_valid = 1'b1;
               next_q.bus_addr  = {p_line, `NT_OFS_ZERO};
               next_q.bus_data  = lane_data;
               next_q.bus_be    = lane_be;
               next_q.bus_wc    = 1'b0;
               next_q.p_live    = 1'b0;
               next_q.st        = ST_DRAIN;
            end
            else if (q.p_l1 || q.p_l2)
            begin
               next_q.evict_valid = 1'b1;
               next_q.evict_addr  = {p_line, `NT_OFS_ZERO};
               next_q.st          = ST_EVICT;
            end
            else
            begin
               next_q.wc_valid  = 1'b1;
               next_q.wc_line   = p_line;
               next_q.wc_data   = merged_data;
               next_q.wc_be     = merged_be;
               next_q.p_live    = 1'b0;
               next_q.req_ready = 1'b1;
               next_q.st        = ST_IDLE;
            end
         end
         ST_DRAIN:
         begin
            if (bus_ready)
            begin
               next_q.bus_valid = 1'b0;
               // the request that forced the drain is retried from EXEC
               if (q.p_live)
               begin
                  next_q.st = ST_EXEC;
               end
               else
               begin
                  next_q.req_ready = 1'b1;
                  next_q.st        = ST_IDLE;
               end
            end
         end
         ST_EVICT:
         begin
            if (evict_ready)
            begin
               next_q.evict_valid = 1'b0;
               // hits cleared so the retried store merges into the buffer
               next_q.p_l1        = 1'b0;
               next_q.p_l2        = 1'b0;
               next_q.st          = ST_EXEC;
            end
         end
         ST_FILL:
         begin
            if (fill_ready)
            begin
               next_q.fill_valid = 1'b0;
               next_q.p_live     = 1'b0;
               next_q.req_ready  = 1'b1;
               next_q.st         = ST_IDLE;
            end
         end
         default:
         begin
            // unused state codes fall back to idle, dropping the request and strobes but keeping the buffered line
            next_q.st          = ST_IDLE;
            next_q.req_ready   = 1'b0;
            next_q.p_live      = 1'b0;
            next_q.bus_valid   = 1'b0;
            next_q.evict_valid = 1'b0;
            next_q.fill_valid  = 1'b0;
         end
      endcase
   end

   // synchronous reset clears every field: idle, not ready, nothing valid
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         q <= '0;
      end
      else
      begin
         q <= next_q;
      end
   end

   // every output is a field of the registered state
   assign req_ready   = q.req_ready;
   assign evict_valid = q.evict_valid;
   assign evict_addr  = q.evict_addr;
   assign fill_valid  = q.fill_valid;
   assign fill_addr   = q.fill_addr;
   assign fill_l1     = q.fill_l1;
   assign fill_l2     = q.fill_l2;
   assign fill_nt     = q.fill_nt;
   assign bus_valid   = q.bus_valid;
   assign bus_addr    = q.bus_addr;
   assign bus_data    = q.bus_data;
   assign bus_be      = q.bus_be;
   assign bus_wc      = q.bus_wc;
   assign fence_done  = q.fence_done;

endmodule : nontemporal_store_prefetch_fence

`default_nettype wire

//--- design/nt_params.svh
// widths, line offsets and field positions for the non-temporal store unit
`ifndef NT_PARAMS_SVH
`define NT_PARAMS_SVH

`define NT_ADDR_W      32
`define NT_OFS_W       5
`define NT_LINE_BYTES  32
`define NT_LINE_BITS   256
`define NT_REQ_BITS    128
`define NT_QW_BYTES    8
`define NT_PS_BYTES    16
`define NT_MASK_W      8
`define NT_OFS_ZERO    5'h00
`define NT_QW_LANE_HI  4
`define NT_QW_LANE_LO  3
`define NT_PS_LANE     4

`endif

//--- design/nt_pkg.sv
// types shared by the non-temporal store, prefetch and fence unit
`default_nettype none
`include "nt_params.svh"

package nt_pkg;

   typedef enum logic [2:0]
   {
      NT_STORE_QUADWORD      = 3'h0,
      NT_STORE_PACKED_SINGLE = 3'h1,
      MASKED_BYTE_STORE      = 3'h2,
      PREFETCH_ALL_LEVELS    = 3'h3,
      PREFETCH_LEVEL_TWO_A   = 3'h4,
      PREFETCH_LEVEL_TWO_B   = 3'h5,
      PREFETCH_NONTEMPORAL   = 3'h6,
      STORE_FENCE            = 3'h7
   } op_t;

   typedef enum logic [2:0]
   {
      UNCACHEABLE_TYPE     = 3'h0,
      WRITE_COMBINING_TYPE = 3'h1,
      WRITE_THROUGH_TYPE   = 3'h4,
      WRITE_PROTECTED_TYPE = 3'h5,
      WRITE_BACK_TYPE      = 3'h6
   } mem_type_t;

   typedef enum logic [2:0]
   {
      ST_IDLE  = 3'h0,
      ST_EXEC  = 3'h1,
      ST_DRAIN = 3'h3,
      ST_EVICT = 3'h2,
      ST_FILL  = 3'h6
   } state_t;

endpackage : nt_pkg

`default_nettype wire

//--- tb/nt_checker.sv
// assertion checker for the non-temporal store, prefetch and fence unit
`default_nettype none
module nt_checker
(
   input wire logic              clk,
   input wire logic              resetn,
   input wire logic              req_valid,
   input wire logic              req_ready,
   input wire nt_pkg::op_t       req_op,
   input wire nt_pkg::mem_type_t req_mtype,
   input wire logic              cache_l1_hit,
   input wire logic              cache_l2_hit,
   input wire logic              evict_valid,
   input wire logic [31:0]       evict_addr,
   input wire logic              evict_ready,
   input wire logic              fill_valid,
   input wire logic              fill_l1,
   input wire logic              fill_l2,
   input wire logic              fill_nt,
   input wire logic              bus_valid,
   input wire logic [31:0]       bus_addr,
   input wire logic [255:0]      bus_data,
   input wire logic              bus_wc,
   input wire logic              bus_ready,
   input wire logic              fence_done
);
   timeunit 1ns;
   timeprecision 1ps;
   import nt_pkg::*;
   logic take;
   logic st;
   logic cach;
   assign take = req_valid && req_ready;
   assign st   = req_op <= MASKED_BYTE_STORE;
   assign cach = req_mtype inside {WRITE_BACK_TYPE, WRITE_THROUGH_TYPE,
                                   WRITE_COMBINING_TYPE};
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   sequence s_store_hit;
      take && st && cach && (cache_l1_hit || cache_l2_hit);
   endsequence
   sequence s_pf_cold;
      take && req_op == PREFETCH_ALL_LEVELS && !cache_l1_hit && !cache_l2_hit;
   endsequence
   sequence s_pf_warm;
      take && cache_l1_hit &&
      req_op inside {[PREFETCH_ALL_LEVELS:PREFETCH_NONTEMPORAL]};
   endsequence
   a_evict_on_hit : assert property (s_store_hit |-> ##[1:40] evict_valid)
      else $error("no eviction after store to cached line");
   a_evict_hold : assert property (evict_valid && !evict_ready |=>
      evict_valid && $stable(evict_addr)) else $error("eviction dropped");
   a_uc_direct : assert property (take && st && !cach |->
      ##[1:40] bus_valid && !bus_wc) else $error("uncached store combined");
   a_bus_align : assert property (bus_valid |-> bus_addr[4:0] == 5'h00)
      else $error("bus write not line aligned");
   a_bus_hold : assert property (bus_valid && !bus_ready |=> bus_valid &&
      $stable(bus_data) && $stable(bus_addr)) else $error("bus write changed");
   a_no_alloc : assert property (take && st |=> !fill_valid [*3])
      else $error("store fetched a line");
   a_fill_cold : assert property (s_pf_cold |-> ##2 fill_valid &&
      fill_l1 && fill_l2 && !fill_nt) else $error("all-level fill missing");
   a_no_move : assert property (s_pf_warm |=> !fill_valid [*3])
      else $error("fill of line already near core");
   a_hint_levels : assert property (fill_valid |->
      (fill_nt ? fill_l1 && !fill_l2 : fill_l2)) else $error("bad fill level");
   a_fence_drain : assert property (fence_done |->
      req_ready && !bus_valid && !evict_valid) else $error("fence undrained");
endmodule : nt_checker
bind nontemporal_store_prefetch_fence nt_checker nt_checker_i
   (.clk, .resetn, .req_valid, .req_ready, .req_op, .req_mtype,
    .cache_l1_hit, .cache_l2_hit, .evict_valid, .evict_addr, .evict_ready,
    .fill_valid, .fill_l1, .fill_l2, .fill_nt, .bus_valid, .bus_addr,
    .bus_data, .bus_wc, .bus_ready, .fence_done);
`default_nettype wire

//--- tb/nt_mem_side.sv
// cache and memory bus model: random stalls, byte memory, transfer counts
`default_nettype none
module nt_mem_side
(
   input  wire logic         clk,
   input  wire logic         slow,
   input  wire logic         evict_valid,
   input  wire logic         fill_valid,
   input  wire logic         fill_l1,
   input  wire logic         fill_l2,
   input  wire logic         fill_nt,
   input  wire logic         bus_valid,
   input  wire logic [31:0]  bus_addr,
   input  wire logic [255:0] bus_data,
   input  wire logic [31:0]  bus_be,
   input  wire logic         bus_wc,
   output var  logic         evict_ready,
   output var  logic         fill_ready,
   output var  logic         bus_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [logic [31:0]];
   int         n_bus;
   int         n_evict;
   int         n_fill;
   logic [2:0] levels;
   logic       last_wc;
   initial {evict_ready, fill_ready, bus_ready} = 3'h0;
   always @(negedge clk)
      {evict_ready, fill_ready, bus_ready} <= slow ? 3'($urandom) : 3'h7;
   always @(posedge clk)
   begin
      if (evict_valid && evict_ready)
         n_evict++;
      if (fill_valid && fill_ready)
      begin
         n_fill++;
         levels = {fill_l1, fill_l2, fill_nt};
      end
      // only written bytes become visible to other agents
      if (bus_valid && bus_ready)
      begin
         n_bus++;
         last_wc = bus_wc;
         for (int k = 0; k < 32; k++)
            if (bus_be[k])
               mem[bus_addr + 32'(k)] = bus_data[8*k +: 8];
      end
   end
endmodule : nt_mem_side
`default_nettype wire

//--- tb/tb_nontemporal_store_prefetch_fence.sv
// self-checking bench for the non-temporal store, prefetch and fence unit
`default_nettype none
module tb_nontemporal_store_prefetch_fence;
   timeunit 1ns;
   timeprecision 1ps;
   import nt_pkg::*;
   logic         clk, resetn, req_valid, req_ready, cache_l1_hit, cache_l2_hit;
   logic         evict_valid, evict_ready, fill_valid, fill_l1, fill_l2;
   logic         fill_nt, fill_ready, bus_valid, bus_wc, bus_ready, fence_done;
   logic         slow;
   op_t          req_op;
   mem_type_t    req_mtype;
   logic [31:0]  req_addr, evict_addr, fill_addr, bus_addr, bus_be, pa;
   logic [127:0] req_data;
   logic [255:0] bus_data;
   logic [7:0]   req_mask;
   logic [7:0]   ref_mem [logic [31:0]];
   int           err_count, check_count, exp_evict, n_fence, nb, nf;
   mem_type_t    mts [5] = '{UNCACHEABLE_TYPE, WRITE_COMBINING_TYPE,
                     WRITE_THROUGH_TYPE, WRITE_PROTECTED_TYPE, WRITE_BACK_TYPE};
   nontemporal_store_prefetch_fence nontemporal_store_prefetch_fence_i
      (.clk, .resetn, .req_valid, .req_ready, .req_op, .req_addr, .req_data,
       .req_mask, .req_mtype, .cache_l1_hit, .cache_l2_hit, .evict_valid,
       .evict_addr, .evict_ready, .fill_valid, .fill_addr, .fill_l1, .fill_l2,
       .fill_nt, .fill_ready, .bus_valid, .bus_addr, .bus_data, .bus_be,
       .bus_wc, .bus_ready, .fence_done);
   nt_mem_side nt_mem_side_i
      (.clk, .slow, .evict_valid, .fill_valid, .fill_l1, .fill_l2, .fill_nt,
       .bus_valid, .bus_addr, .bus_data, .bus_be, .bus_wc, .evict_ready,
       .fill_ready, .bus_ready);
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         err_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic report_and_stop;
      if (err_count == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : report_and_stop
   function automatic logic [2:0] exp_lv(input op_t op);
      case (op)
         PREFETCH_ALL_LEVELS:  return 3'h6;
         PREFETCH_NONTEMPORAL: return 3'h5;
         default:              return 3'h2;
      endcase
   endfunction : exp_lv
   function automatic logic [31:0] exp_be(op_t op, logic [31:0] a,
                                          logic [7:0] m);
      case (op)
         NT_STORE_QUADWORD:      return 32'h000000FF << (8 * a[4:3]);
         MASKED_BYTE_STORE:      return 32'(m) << (8 * a[4:3]);
         NT_STORE_PACKED_SINGLE: return 32'h0000FFFF << (16 * a[4]);
         default:                return 32'h00000000;
      endcase
   endfunction : exp_be
   // called at a falling edge, returns at a falling edge once idle again
   task automatic do_op(op_t op, logic [31:0] a, mem_type_t mt, logic h1,
                        logic h2);
      int          n;
      logic [31:0] be;
      req_op = op;
      req_addr = a;
      req_mtype = mt;
      req_data = {$urandom, $urandom, $urandom, $urandom};
      req_mask = 8'($urandom) | 8'h01;
      cache_l1_hit = h1;
      cache_l2_hit = h2;
      req_valid = 1'b1;
      for (n = 0; n < 300 && !req_ready; n++)
         @(negedge clk);
      @(negedge clk);
      req_valid = 1'b0;
      be = exp_be(op, a, req_mask);
      for (int k = 0; k < 32; k++)
         if (be[k])
            ref_mem[{a[31:5], 5'h00} + 32'(k)] = op == NT_STORE_PACKED_SINGLE ?
               req_data[8*(k%16) +: 8] : req_data[8*(k%8) +: 8];
      if (op <= MASKED_BYTE_STORE && (h1 || h2) && mt inside {WRITE_BACK_TYPE,
          WRITE_THROUGH_TYPE, WRITE_COMBINING_TYPE})
         exp_evict++;
      for (n = 0; n < 300 && !req_ready; n++)
         @(negedge clk);
      check(req_ready, 1'b1);
   endtask : do_op
   task automatic cmp_mem;
      logic [7:0] v;
      foreach (ref_mem[a])
      begin
         v = nt_mem_side_i.mem.exists(a) ? nt_mem_side_i.mem[a] : 8'hXX;
         check(v, ref_mem[a]);
      end
   endtask : cmp_mem
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(negedge clk)
      if (fence_done === 1'b1)
         n_fence++;
   initial
   begin
      #(5ns * 60000);
      err_count++;
      report_and_stop();
   end
   initial
   begin
      void'($urandom(32'h4C75));
      {resetn, req_valid, cache_l1_hit, cache_l2_hit, slow} = 5'h00;
      req_op = NT_STORE_QUADWORD;
      {req_addr, req_data, req_mask} = '0;
      req_mtype = WRITE_BACK_TYPE;
      repeat (10) @(negedge clk);
      resetn = 1'b1;
      @(negedge clk);
      for (int h = 3; h < 7; h++)
         for (int c = 0; c < 4; c++)
         begin
            nf = nt_mem_side_i.n_fill;
            pa = $urandom;
            do_op(op_t'(h), pa, WRITE_BACK_TYPE, c[0], c[1]);
            check(nt_mem_side_i.n_fill - nf,
                  !(c[0] || (c[1] && h inside {4, 5})));
            if (nt_mem_side_i.n_fill != nf)
            begin
               check(nt_mem_side_i.levels, exp_lv(op_t'(h)));
               check(fill_addr, {pa[31:5], 5'h00});
            end
         end
      nb = nt_mem_side_i.n_bus;
      nf = n_fence;
      do_op(NT_STORE_QUADWORD, 32'h2000, WRITE_BACK_TYPE, 1'b0, 1'b0);
      do_op(NT_STORE_QUADWORD, 32'h2008, WRITE_COMBINING_TYPE, 1'b0, 1'b0);
      do_op(NT_STORE_PACKED_SINGLE, 32'h2010, WRITE_THROUGH_TYPE, 1'b0, 1'b1);
      check(evict_addr, 32'h2000);
      check(nt_mem_side_i.n_bus - nb, 0);
      do_op(STORE_FENCE, 32'h0, WRITE_BACK_TYPE, 1'b0, 1'b0);
      check(nt_mem_side_i.n_bus - nb, 1);
      check(nt_mem_side_i.last_wc, 1);
      @(negedge clk);
      check(n_fence - nf, 1);
      cmp_mem();
      do_op(MASKED_BYTE_STORE, 32'h2018, WRITE_BACK_TYPE, 1'b0, 1'b0);
      nb = nt_mem_side_i.n_bus;
      do_op(MASKED_BYTE_STORE, 32'h3000, UNCACHEABLE_TYPE, 1'b0, 1'b0);
      check(nt_mem_side_i.n_bus - nb, 2);
      check(nt_mem_side_i.last_wc, 0);
      cmp_mem();
      slow = 1'b1;
      repeat (300)
      begin
         req_mtype = mts[$urandom_range(4)];
         do_op(op_t'($urandom_range(7)), 32'h4000 + $urandom_range(127),
               req_mtype, req_mtype inside {WRITE_BACK_TYPE,
               WRITE_THROUGH_TYPE, WRITE_COMBINING_TYPE} && 1'($urandom),
               1'b0);
      end
      do_op(STORE_FENCE, 32'h0, WRITE_BACK_TYPE, 1'b0, 1'b0);
      cmp_mem();
      check(nt_mem_side_i.n_evict, exp_evict);
      report_and_stop();
   end
endmodule : tb_nontemporal_store_prefetch_fence
`default_nettype wire
